/* src/mii_mac_pin_interface.sv */
// Purpose: mii pin side of an ethernet mac, byte streams inside
// Assumes: phy supplies both link clocks; config inputs are sys levels
// Notes:   ce_i freezes the system domain and the fifo write side
`timescale 1ns/1ps
`default_nettype none
`include "mii_defs.svh"
module mii_mac_pin_interface (
  // system clock and control
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // configuration
  input  wire logic              serial_mode_i,
  input  wire logic              full_duplex_i,
  // transmit byte stream
  input  wire logic              tx_valid_i,
  input  wire mii_pkg::tx_item_t tx_item_i,
  output logic                   tx_ready_o,
  // receive byte stream
  output logic                   rx_valid_o,
  output var mii_pkg::rx_item_t  rx_item_o,
  // medium status
  output logic                   medium_busy_o,
  output logic                   collision_o,
  // mii transmit pins
  input  wire logic              mii_tx_clock_i,
  output logic                   mii_tx_enable_o,
  output logic                   mii_tx_error_o,
  output logic [3:0]             mii_tx_nibble_o,
  // mii receive pins
  input  wire logic              mii_rx_clock_i,
  input  wire logic              mii_rx_valid_i,
  input  wire logic              mii_rx_error_i,
  input  wire logic [3:0]        mii_rx_nibble_i,
  input  wire logic              mii_collision_i,
  input  wire logic              mii_carrier_sense_i
);
  import mii_pkg::*;

  typedef struct packed {
    tx_state_t  state;
    tx_item_t   cur;
    logic [2:0] phase;
    logic       ser;
    logic       en;
    logic       er;
    logic [3:0] nib;
  } tx_st_t;
  typedef struct packed {
    rx_pins_t   pin;
    logic [7:0] acc;
    logic [2:0] phase;
    logic       have;
    logic       bad;
    rx_item_t   pend;
  } rx_st_t;
  typedef struct packed {
    logic     rx_valid;
    rx_item_t rx_item;
    logic     busy;
    logic     col;
  } sys_st_t;

  tx_st_t   txs;
  tx_st_t   next_txs;
  rx_st_t   rxs;
  rx_st_t   next_rxs;
  sys_st_t  ss;
  sys_st_t  next_ss;
  logic     tx_rst_n;
  logic     ser_t;
  logic     fd_t;
  logic     crs_t;
  logic     rx_rst_n;
  logic     ser_r;
  logic     crs_s;
  logic     col_s;
  logic     tx_full;
  logic     tx_empty;
  logic     tx_pop;
  tx_item_t tx_head;
  logic     rx_push;
  rx_item_t rx_w;
  logic     rx_full;
  logic     rx_empty;
  logic     rx_pop;
  rx_item_t rx_head;

  // nibble or bit of a byte for a given phase, low nibble first
  function automatic logic [3:0] nib_sel(input logic [7:0] d, input logic [2:0] ph,
                                         input logic ser);
    if (ser)
      return {3'h0, d[ph]};
    return ph[0] ? d[7:4] : d[3:0];
  endfunction : nib_sel

  // ****************************************
  // crossings
  // ****************************************
  mii_sync2 #(.W(4)) u_sync_tx (
    .clk_i (mii_tx_clock_i),
    .d_i   ({rst_n_i, serial_mode_i, full_duplex_i, mii_carrier_sense_i}),
    .q_o   ({tx_rst_n, ser_t, fd_t, crs_t})
  );
  mii_sync2 #(.W(2)) u_sync_rx (
    .clk_i (mii_rx_clock_i),
    .d_i   ({rst_n_i, serial_mode_i}),
    .q_o   ({rx_rst_n, ser_r})
  );
  mii_sync2 #(.W(2)) u_sync_sys (
    .clk_i (clk_sys_i),
    .d_i   ({mii_carrier_sense_i, mii_collision_i}),
    .q_o   ({crs_s, col_s})
  );
  mii_cdc_fifo #(.W($bits(tx_item_t))) u_tx_fifo (
    .clk_wr_i   (clk_sys_i),
    .rst_wr_n_i (rst_n_i),
    .wr_en_i    (ce_i && tx_valid_i),
    .wr_data_i  (tx_item_i),
    .full_o     (tx_full),
    .clk_rd_i   (mii_tx_clock_i),
    .rst_rd_n_i (tx_rst_n),
    .rd_en_i    (tx_pop),
    .rd_data_o  (tx_head),
    .empty_o    (tx_empty)
  );
  mii_cdc_fifo #(.W($bits(rx_item_t))) u_rx_fifo (
    .clk_wr_i   (mii_rx_clock_i),
    .rst_wr_n_i (rx_rst_n),
    .wr_en_i    (rx_push),
    .wr_data_i  (rx_w),
    .full_o     (rx_full),
    .clk_rd_i   (clk_sys_i),
    .rst_rd_n_i (rst_n_i),
    .rd_en_i    (rx_pop),
    .rd_data_o  (rx_head),
    .empty_o    (rx_empty)
  );

  // ****************************************
  // transmit, link clock domain
  // ****************************************
  always_comb
  begin
    next_txs = txs;
    tx_pop   = 1'b0;
    unique case (txs.state)
      TX_IDLE:
      begin
        next_txs.en  = 1'b0;
        next_txs.er  = 1'b0;
        next_txs.nib = `MII_NIB_IDLE;
        if (!tx_empty && !(crs_t && !fd_t))
        begin
          tx_pop         = 1'b1;
          next_txs.state = TX_SEND;
          next_txs.ser   = ser_t;
          next_txs.cur   = tx_head;
          next_txs.phase = `MII_PHASE_RST;
          next_txs.en    = 1'b1;
          next_txs.er    = !ser_t && tx_head.err;
          next_txs.nib   = nib_sel(tx_head.data, `MII_PHASE_RST, ser_t);
        end
      end
      TX_SEND:
      begin
        if (txs.phase != (txs.ser ? `MII_SER_LAST : `MII_NIB_LAST))
        begin
          next_txs.phase = txs.phase + 3'h1;
          next_txs.nib   = nib_sel(txs.cur.data, next_txs.phase, txs.ser);
        end
        else if (!txs.cur.last && !tx_empty)
        begin
          tx_pop         = 1'b1;
          next_txs.cur   = tx_head;
          next_txs.phase = `MII_PHASE_RST;
          next_txs.er    = !txs.ser && tx_head.err;
          next_txs.nib   = nib_sel(tx_head.data, `MII_PHASE_RST, txs.ser);
        end
        else
        begin
          next_txs.state = TX_IDLE;
          next_txs.en    = 1'b0;
          next_txs.er    = 1'b0;
          next_txs.nib   = `MII_NIB_IDLE;
        end
      end
      default:
      begin
        next_txs.state = TX_IDLE;
        next_txs.en    = 1'b0;
        next_txs.er    = 1'b0;
        next_txs.nib   = `MII_NIB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mii_tx_clock_i)
  begin
    if (!tx_rst_n)
    begin
      txs.state <= TX_IDLE;
      txs.cur   <= '0;
      txs.phase <= `MII_PHASE_RST;
      txs.ser   <= 1'b0;
      txs.en    <= 1'b0;
      txs.er    <= 1'b0;
      txs.nib   <= `MII_NIB_IDLE;
    end
    else
      txs <= next_txs;
  end

  assign mii_tx_enable_o = txs.en;
  assign mii_tx_error_o  = txs.er;
  assign mii_tx_nibble_o = txs.nib;

  a_tx_start : assert property (
    @(posedge mii_tx_clock_i) disable iff (!tx_rst_n)
    (txs.state == TX_IDLE && tx_pop && !ser_t)
      |=> mii_tx_enable_o && mii_tx_nibble_o == $past(tx_head.data[3:0]))
    else $error("enable not raised with first nibble");
  a_tx_end : assert property (
    @(posedge mii_tx_clock_i) disable iff (!tx_rst_n)
    (txs.en && txs.cur.last && txs.phase == (txs.ser ? `MII_SER_LAST : `MII_NIB_LAST))
      |=> !mii_tx_enable_o)
    else $error("enable held past final nibble");
  a_tx_serial : assert property (
    @(posedge mii_tx_clock_i) disable iff (!tx_rst_n)
    (txs.en && txs.ser) |-> mii_tx_nibble_o[3:1] == 3'h0 && !mii_tx_error_o)
    else $error("serial mode drives upper bits");
  a_tx_quiet : assert property (
    @(posedge mii_tx_clock_i) disable iff (!tx_rst_n)
    !mii_tx_enable_o |-> mii_tx_nibble_o == `MII_NIB_IDLE)
    else $error("data driven without enable");
  a_tx_error : assert property (
    @(posedge mii_tx_clock_i) disable iff (!tx_rst_n)
    (mii_tx_enable_o && !txs.ser) |-> mii_tx_error_o == txs.cur.err)
    else $error("transmit error does not follow byte");
  a_tx_pair : assert property (
    @(posedge mii_tx_clock_i) disable iff (!tx_rst_n)
    (txs.en && !txs.ser && txs.phase == `MII_PHASE_RST)
      |=> mii_tx_nibble_o == $past(txs.cur.data[7:4]))
    else $error("high nibble not second");

  // ****************************************
  // receive, link clock domain
  // ****************************************
  always_comb
  begin
    next_rxs     = rxs;
    rx_push      = 1'b0;
    rx_w         = rxs.pend;
    next_rxs.pin = {mii_rx_valid_i, mii_rx_error_i, mii_rx_nibble_i};
    if (rxs.pin.valid)
    begin
      if (rxs.pin.error)
        next_rxs.bad = 1'b1;
      if (ser_r)
        next_rxs.acc = {rxs.pin.nibble[0], rxs.acc[7:1]};
      else
        next_rxs.acc = {rxs.pin.nibble, rxs.acc[7:4]};
      next_rxs.phase = rxs.phase + 3'h1;
      if (rxs.phase == (ser_r ? `MII_SER_LAST : `MII_NIB_LAST))
      begin
        next_rxs.phase     = `MII_PHASE_RST;
        rx_push            = rxs.have;
        rx_w.last          = 1'b0;
        next_rxs.have      = 1'b1;
        next_rxs.pend.data = next_rxs.acc;
      end
    end
    else
    begin
      rx_push        = rxs.have;
      rx_w.last      = 1'b1;
      rx_w.bad       = rxs.bad || rxs.phase != `MII_PHASE_RST;
      next_rxs.have  = 1'b0;
      next_rxs.bad   = 1'b0;
      next_rxs.phase = `MII_PHASE_RST;
    end
    if (rx_push && rx_full)
      next_rxs.bad = 1'b1;
  end

  always_ff @(posedge mii_rx_clock_i)
  begin
    if (!rx_rst_n)
    begin
      rxs.pin   <= '0;
      rxs.acc   <= `MII_BYTE_RST;
      rxs.phase <= `MII_PHASE_RST;
      rxs.have  <= 1'b0;
      rxs.bad   <= 1'b0;
      rxs.pend  <= '0;
    end
    else
      rxs <= next_rxs;
  end

  a_rx_bad_mark : assert property (
    @(posedge mii_rx_clock_i) disable iff (!rx_rst_n)
    (rxs.pin.valid && rxs.pin.error) |=> rxs.bad)
    else $error("receive error not marked");
  a_rx_err_ignore : assert property (
    @(posedge mii_rx_clock_i) disable iff (!rx_rst_n)
    (!rxs.pin.valid && rxs.pin.error) |=> !rxs.bad && !rxs.have)
    else $error("receive error taken outside valid");
  a_rx_take_valid : assert property (
    @(posedge mii_rx_clock_i) disable iff (!rx_rst_n)
    (rx_push && !rx_w.last) |-> rxs.pin.valid)
    else $error("byte taken without valid");
  a_rx_pair : assert property (
    @(posedge mii_rx_clock_i) disable iff (!rx_rst_n)
    (rxs.pin.valid && !ser_r && rxs.phase == `MII_NIB_LAST)
      |=> rxs.pend.data == {$past(rxs.pin.nibble), $past(rxs.acc[7:4])})
    else $error("received nibbles misordered");

  // ****************************************
  // system domain
  // ****************************************
  assign rx_pop     = ce_i && !rx_empty;
  assign tx_ready_o = !tx_full;

  always_comb
  begin
    next_ss          = ss;
    next_ss.rx_valid = rx_pop;
    if (rx_pop)
      next_ss.rx_item = rx_head;
    next_ss.busy     = crs_s;
    next_ss.col      = col_s && !full_duplex_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ss.rx_valid <= 1'b0;
      ss.rx_item  <= '0;
      ss.busy     <= 1'b0;
      ss.col      <= 1'b0;
    end
    else if (ce_i)
      ss <= next_ss;
  end

  assign rx_valid_o    = ss.rx_valid && ce_i;
  assign rx_item_o     = ss.rx_item;
  assign medium_busy_o = ss.busy;
  assign collision_o   = ss.col;

  a_col_duplex : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && full_duplex_i) |=> !collision_o)
    else $error("collision reported in full duplex");
  a_busy_sense : assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ce_i && crs_s) |=> medium_busy_o)
    else $error("carrier sense not shown as busy");
endmodule : mii_mac_pin_interface
`default_nettype wire

/* src/mii_defs.svh */
// Purpose: constants of the mii pin interface
// Assumes: included by the package, the pin interface module and the fifo module
// Notes:   phase counts are link clock cycles, fifo depth is in entries
`ifndef MII_DEFS_SVH
`define MII_DEFS_SVH
`define MII_FIFO_DEPTH 4
`define MII_PTR_W      3
`define MII_PTR_RST    3'h0
`define MII_NIB_LAST   3'h1
`define MII_SER_LAST   3'h7
`define MII_PHASE_RST  3'h0
`define MII_NIB_IDLE   4'h0
`define MII_BYTE_RST   8'h00
`endif

/* src/mii_pkg.sv */
// Purpose: types of the mii pin interface
// Assumes: mii_defs.svh holds the numbers
// Notes:   none
`include "mii_defs.svh"
package mii_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_t;
  typedef struct packed {
    logic       last;
    logic       err;
    logic [7:0] data;
  } tx_item_t;
  typedef struct packed {
    logic       last;
    logic       bad;
    logic [7:0] data;
  } rx_item_t;
  typedef struct packed {
    logic       valid;
    logic       error;
    logic [3:0] nibble;
  } rx_pins_t;
  function automatic logic [`MII_PTR_W-1:0] bin2gray(input logic [`MII_PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray
endpackage : mii_pkg

/* src/mii_sync2.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: d_i is a level from another domain
// Notes:   no reset, settles after two edges
`timescale 1ns/1ps
`default_nettype none
module mii_sync2 #(
  parameter int W = 1
) (
  // destination clock
  input  wire logic         clk_i,
  // level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t s;
  sync_t next_s;
  always_comb
  begin
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end
  always_ff @(posedge clk_i)
  begin
    s <= next_s;
  end
  assign q_o = s.s2;
endmodule : mii_sync2
`default_nettype wire

/* src/mii_cdc_fifo.sv */
// Purpose: small dual clock fifo with gray pointers
// Assumes: each side has its own synchronous reset
// Notes:   read data is the head entry, first word fall through
`timescale 1ns/1ps
`default_nettype none
`include "mii_defs.svh"
module mii_cdc_fifo #(
  parameter int W = 10
) (
  // write side
  input  wire logic         clk_wr_i,
  input  wire logic         rst_wr_n_i,
  input  wire logic         wr_en_i,
  input  wire logic [W-1:0] wr_data_i,
  output logic              full_o,
  // read side
  input  wire logic         clk_rd_i,
  input  wire logic         rst_rd_n_i,
  input  wire logic         rd_en_i,
  output logic      [W-1:0] rd_data_o,
  output logic              empty_o
);
  import mii_pkg::*;
  typedef struct packed {
    logic [`MII_FIFO_DEPTH-1:0][W-1:0] mem;
    logic [`MII_PTR_W-1:0]             bin;
    logic [`MII_PTR_W-1:0]             gray;
  } wr_st_t;
  typedef struct packed {
    logic [`MII_PTR_W-1:0] bin;
    logic [`MII_PTR_W-1:0] gray;
  } rd_st_t;
  wr_st_t                w;
  wr_st_t                next_w;
  rd_st_t                r;
  rd_st_t                next_r;
  logic [`MII_PTR_W-1:0] rgray_w;
  logic [`MII_PTR_W-1:0] wgray_r;
  // ****************************************
  // pointer crossings
  // ****************************************
  mii_sync2 #(.W(`MII_PTR_W)) u_rg (.clk_i(clk_wr_i), .d_i(r.gray), .q_o(rgray_w));
  mii_sync2 #(.W(`MII_PTR_W)) u_wg (.clk_i(clk_rd_i), .d_i(w.gray), .q_o(wgray_r));
  assign full_o    = (w.gray == {~rgray_w[2:1], rgray_w[0]});
  assign empty_o   = (r.gray == wgray_r);
  assign rd_data_o = w.mem[r.bin[1:0]];
  // ****************************************
  // write side
  // ****************************************
  always_comb
  begin
    next_w = w;
    if (wr_en_i && !full_o)
    begin
      next_w.mem[w.bin[1:0]] = wr_data_i;
      next_w.bin             = w.bin + 3'h1;
      next_w.gray            = bin2gray(next_w.bin);
    end
  end
  always_ff @(posedge clk_wr_i)
  begin
    if (!rst_wr_n_i)
    begin
      w.bin  <= `MII_PTR_RST;
      w.gray <= `MII_PTR_RST;
      w.mem  <= '0;
    end
    else
      w <= next_w;
  end
  // ****************************************
  // read side
  // ****************************************
  always_comb
  begin
    next_r = r;
    if (rd_en_i && !empty_o)
    begin
      next_r.bin  = r.bin + 3'h1;
      next_r.gray = bin2gray(next_r.bin);
    end
  end
  always_ff @(posedge clk_rd_i)
  begin
    if (!rst_rd_n_i)
    begin
      r.bin  <= `MII_PTR_RST;
      r.gray <= `MII_PTR_RST;
    end
    else
      r <= next_r;
  end
endmodule : mii_cdc_fifo
`default_nettype wire

/* tb/mii_phy_model.sv */
// Purpose: behavioural phy on the far side of the mii pins
// Assumes: link clocks run free at 80 ns, unrelated in phase to the system clock
// Notes:   receive frames and status levels are commanded by the bench through tasks
`timescale 1ns/1ps
`default_nettype none
module mii_phy_model (
  // link clocks
  output logic             tx_clock_o,
  output logic             rx_clock_o,
  // transmit pins from the mac
  input  wire logic        tx_enable_i,
  input  wire logic        tx_error_i,
  input  wire logic [3:0]  tx_nibble_i,
  // receive pins to the mac
  output logic             rx_valid_o,
  output logic             rx_error_o,
  output logic [3:0]       rx_nibble_o,
  // medium status
  output logic             collision_o,
  output logic             carrier_sense_o
);
  logic [4:0] tx_q[$];

  initial
  begin
    tx_clock_o      = 1'b0;
    rx_clock_o      = 1'b0;
    rx_valid_o      = 1'b0;
    rx_error_o      = 1'b0;
    rx_nibble_o     = 4'h0;
    collision_o     = 1'b0;
    carrier_sense_o = 1'b0;
  end

  always #40 tx_clock_o = ~tx_clock_o;

  initial
  begin
    #17;
    forever #40 rx_clock_o = ~rx_clock_o;
  end

  // ************************************
  // transmit capture
  // ************************************
  // error only counts while enable is high
  always @(posedge tx_clock_o)
    if (tx_enable_i === 1'b1)
      tx_q.push_back({tx_error_i, tx_nibble_i});

  // ************************************
  // receive frames and status
  // ************************************
  // valid stays high from first to last unit, then valid and error drop and the nibble is inverted
  task automatic send_rx(input logic [31:0] w, input int n, input bit ser, input int err_at,
                         input bit pre_err);
    @(posedge rx_clock_o);
    rx_error_o <= pre_err;
    for (int i = 0; i < n; i++)
    begin
      @(posedge rx_clock_o);
      rx_valid_o  <= 1'b1;
      rx_error_o  <= (i == err_at);
      rx_nibble_o <= ser ? {3'b101, w[i]} : w[4*i +: 4];
    end
    @(posedge rx_clock_o);
    rx_valid_o  <= 1'b0;
    rx_error_o  <= 1'b0;
    rx_nibble_o <= ~rx_nibble_o;
  endtask : send_rx

  // levels hold for as long as the bench leaves them
  task automatic set_status(input bit col, input bit crs);
    @(posedge rx_clock_o);
    collision_o     <= col;
    carrier_sense_o <= crs;
  endtask : set_status
endmodule : mii_phy_model
`default_nettype wire

/* tb/mii_mac_pin_interface_tb.sv */
// Purpose: self-checking bench of the mii pin interface
// Assumes: phy model supplies link clocks and receive frames
// Notes:   no random stimulus
`timescale 1ns/1ps
`default_nettype none
module mii_mac_pin_interface_tb;
  import mii_pkg::*;
  logic             clk_sys_i;
  logic             rst_n_i;
  logic             ce_i;
  logic             serial_mode_i;
  logic             full_duplex_i;
  logic             tx_valid_i;
  tx_item_t         tx_item_i;
  logic             tx_ready_o;
  logic             rx_valid_o;
  rx_item_t         rx_item_o;
  logic             medium_busy_o;
  logic             collision_o;
  logic             tx_clk;
  logic             rx_clk;
  logic             tx_en;
  logic             tx_er;
  logic [3:0]       tx_nib;
  logic             rx_dv;
  logic             rx_er;
  logic [3:0]       rx_nib;
  logic             col;
  logic             crs;
  int               n_mismatch;
  int               n_compared;
  rx_item_t         rx_q[$];

  mii_mac_pin_interface u_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .serial_mode_i(serial_mode_i), .full_duplex_i(full_duplex_i),
    .tx_valid_i(tx_valid_i), .tx_item_i(tx_item_i), .tx_ready_o(tx_ready_o),
    .rx_valid_o(rx_valid_o), .rx_item_o(rx_item_o),
    .medium_busy_o(medium_busy_o), .collision_o(collision_o),
    .mii_tx_clock_i(tx_clk), .mii_tx_enable_o(tx_en), .mii_tx_error_o(tx_er),
    .mii_tx_nibble_o(tx_nib), .mii_rx_clock_i(rx_clk), .mii_rx_valid_i(rx_dv),
    .mii_rx_error_i(rx_er), .mii_rx_nibble_i(rx_nib),
    .mii_collision_i(col), .mii_carrier_sense_i(crs)
  );

  mii_phy_model u_phy (
    .tx_clock_o(tx_clk), .rx_clock_o(rx_clk), .tx_enable_i(tx_en),
    .tx_error_i(tx_er), .tx_nibble_i(tx_nib), .rx_valid_o(rx_dv),
    .rx_error_o(rx_er), .rx_nibble_o(rx_nib), .collision_o(col),
    .carrier_sense_o(crs)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i)
    if (rx_valid_o === 1'b1)
      rx_q.push_back(rx_item_o);

  // ************************************
  // helpers
  // ************************************
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic give_verdict;
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // ************************************
  // scenarios
  // ************************************
  // frame of n bytes offered back to back, pin stream compared unit by unit
  task automatic tx_frame(input logic [31:0] w, input int n, input logic [3:0] errs,
                          input bit ser);
    int         tmo;
    int         per;
    logic       rdy;
    logic [7:0] b;
    u_phy.tx_q.delete();
    per = ser ? 8 : 2;
    @(posedge clk_sys_i);
    serial_mode_i <= ser;
    @(posedge clk_sys_i);
    for (int i = 0; i < n; i++)
    begin
      tx_valid_i <= 1'b1;
      tx_item_i  <= '{last: (i == n - 1), err: errs[i], data: w[8*i +: 8]};
      tmo = 0;
      do
      begin
        @(negedge clk_sys_i);
        rdy = tx_ready_o;
        @(posedge clk_sys_i);
        tmo++;
      end while (rdy !== 1'b1 && tmo < 100);
    end
    tx_valid_i <= 1'b0;
    tmo = 0;
    while (u_phy.tx_q.size() < n * per && tmo < 600)
    begin
      @(posedge clk_sys_i);
      tmo++;
    end
    repeat (20) @(posedge clk_sys_i);
    chk_val(16'(u_phy.tx_q.size()), 16'(n * per));
    for (int k = 0; k < n * per && k < u_phy.tx_q.size(); k++)
    begin
      b = w[8*(k/per) +: 8];
      if (ser)
        chk_val(16'(u_phy.tx_q[k]), {11'h000, 4'h0, b[k%8]});
      else
        chk_val(16'(u_phy.tx_q[k]), {11'h000, errs[k/2], b[4*(k%2) +: 4]});
    end
  endtask : tx_frame

  // received frame must arrive as nb bytes, the last one marked
  task automatic rx_frame(input logic [31:0] w, input int n, input bit ser, input int err_at,
                          input bit pre_err, input int nb, input bit bad);
    int       tmo;
    rx_item_t e;
    rx_q.delete();
    @(posedge clk_sys_i);
    serial_mode_i <= ser;
    u_phy.send_rx(w, n, ser, err_at, pre_err);
    tmo = 0;
    while (rx_q.size() < nb && tmo < 400)
    begin
      @(posedge clk_sys_i);
      tmo++;
    end
    repeat (20) @(posedge clk_sys_i);
    chk_val(16'(rx_q.size()), 16'(nb));
    for (int i = 0; i < nb && i < rx_q.size(); i++)
    begin
      e.last = (i == nb - 1);
      e.bad  = (i == nb - 1) && bad;
      e.data = w[8*i +: 8];
      chk_val({6'h00, rx_q[i]}, {6'h00, e});
    end
  endtask : rx_frame

  // status pins reach the system side, collision masked in full duplex
  task automatic status_check;
    u_phy.set_status(1'b1, 1'b1);
    repeat (10) @(posedge clk_sys_i);
    chk_val({15'h0000, collision_o}, 16'h0001);
    chk_val({15'h0000, medium_busy_o}, 16'h0001);
    full_duplex_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    chk_val({15'h0000, collision_o}, 16'h0000);
    u_phy.set_status(1'b0, 1'b0);
    repeat (10) @(posedge clk_sys_i);
    chk_val({15'h0000, medium_busy_o}, 16'h0000);
    ce_i <= 1'b0;
    u_phy.set_status(1'b0, 1'b1);
    repeat (10) @(posedge clk_sys_i);
    chk_val({15'h0000, medium_busy_o}, 16'h0000);
    ce_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    chk_val({15'h0000, medium_busy_o}, 16'h0001);
    u_phy.set_status(1'b0, 1'b0);
  endtask : status_check

  // ************************************
  // main sequence and watchdog
  // ************************************
  initial
  begin
    n_mismatch    = 0;
    n_compared    = 0;
    rst_n_i       = 1'b0;
    ce_i          = 1'b1;
    serial_mode_i = 1'b0;
    full_duplex_i = 1'b0;
    tx_valid_i    = 1'b0;
    tx_item_i     = '0;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    tx_frame(32'h00A3_D555, 3, 4'b0100, 1'b0);
    tx_frame(32'h0000_00B4, 1, 4'b0001, 1'b1);
    rx_frame(32'h0000_A3D5, 4, 1'b0, -1, 1'b1, 2, 1'b0);
    rx_frame(32'h0000_007E, 2, 1'b0, 1, 1'b0, 1, 1'b1);
    rx_frame(32'h0000_0096, 8, 1'b1, -1, 1'b0, 1, 1'b0);
    status_check();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    give_verdict();
  end
endmodule : mii_mac_pin_interface_tb
`default_nettype wire
